// *** inc/frt_cfg.svh ***
`ifndef FRT_CFG_SVH
`define FRT_CFG_SVH
`define FRT_ADDR_W        8
`define FRT_OFF_CTRL1     8'h00
`define FRT_OFF_CTRL2     8'h04
`define FRT_OFF_STAT      8'h08
`define FRT_OFF_CAP1_HI   8'h0c
`define FRT_OFF_CAP1_LO   8'h10
`define FRT_OFF_CNT_HI    8'h14
`define FRT_OFF_CNT_LO    8'h18
`define FRT_OFF_ACNT_HI   8'h1c
`define FRT_OFF_ACNT_LO   8'h20
`define FRT_OFF_CAP2_HI   8'h24
`define FRT_OFF_CAP2_LO   8'h28
`define FRT_OFF_SYS       8'h2c
`define FRT_CNT_RELOAD    16'hfffc
`define FRT_CNT_TOP       16'hffff
`define FRT_B_CAPIE       7
`define FRT_B_OVFIE       5
`define FRT_B_EDGE1       1
`define FRT_B_OPM         4
`define FRT_B_PWM         5
`define FRT_B_CC_LO       2
`define FRT_B_EDGE2       1
`define FRT_B_EXT_CLOCK_EDGE_SELECT       0
`define FRT_B_CF1         7
`define FRT_B_CF2         6
`define FRT_B_OVF         5
`define FRT_B_IMASK       0
`define FRT_B_HALT        1
`define FRT_CC_DIV2       2'b00
`define FRT_CC_DIV4       2'b01
`define FRT_CC_DIV8       2'b10
`define FRT_CC_EXT        2'b11
`define FRT_EXT_GAP       3'd4
`endif

// *** inc/frt_pkg.sv ***
package frt_pkg;
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
  } frt_req_t;
  typedef enum logic [1:0] {
    FRT_DP_IDLE = 2'b01,
    FRT_DP_BUSY = 2'b10
  } frt_dp_t;
endpackage

// *** rtl/frt_timer.sv ***
// How it works
// - counter steps once per timer tick; tick is hclk divided by 2, 4 or 8, or an external pin edge
// - internal-clock wrap period is 65536 ticks: 131072/262144/524288 cycles
// - writing counter or alt-counter low byte reloads the counter to fffc
// - reset value is fffc; fffc is the only reload value in any mode
// - high-byte read latches low byte; frozen until low byte read
// - low-byte read outside a sequence returns the live low byte
// - overflow flag set on roll from ffff to 0000
// - overflow irq only with enable set and cpu mask clear; stays pending
// - overflow flag clears after status read then counter low access
// - alt-counter low byte accesses never clear the overflow flag
// - counter holds in halt, resumes from held count
// - clock select 11 picks the external pin, edge set by edge bit
// - external edges sampled on hclk, source must leave 4 cycles between
// - capture edge copies counter to capture register and sets its flag
// - channel one edge from control one, channel two from control two
// - capture irq with shared enable and cpu mask clear; stays pending
// - capture flag clears after status read then that capture low access
// - after capture high read, captures inhibited until capture low read
// - in one-pulse or pwm mode only channel two captures
// - capture pins always feed capture logic, output-driven ones too
// - flash variant: channel two absent, its flags forced to zero
// - a timer input on a non-bonded pin reads as one
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "frt_cfg.svh"
module frt_timer
  import frt_pkg::*;
#(
  parameter int CNT_W       = 16,
  parameter bit FLASH_VAR   = 1'b0,
  parameter bit CAP1_BONDED = 1'b1,
  parameter bit CAP2_BONDED = 1'b1,
  parameter bit EXT_BONDED  = 1'b1
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        capture_pin_one,
  input  wire logic        capture_pin_two,
  input  wire logic        ext_timer_clock_pin,
  output logic             timer_irq
);
  // byte lanes and the fffc reload assume a 16-bit counter
  if (CNT_W != 16) begin : g_bad_width
    $error("frt_timer supports only a 16-bit counter");
  end

  frt_req_t   req_q;
  frt_dp_t    dp_q;
  logic [7:0] ctrl1_q, ctrl2_q, sys_q;
  logic [15:0] cnt_q, cap1_q, cap2_q;
  logic [7:0] lo_latch_q;
  logic       seq_q;
  logic       ovf_q, cf1_q, cf2_q;
  logic       ovf_arm_q, cf1_arm_q, cf2_arm_q;
  logic       cap1_inh_q, cap2_inh_q;
  logic [2:0] pre_q;
  logic       ext_s1_q, ext_s2_q, ext_s3_q;
  logic       ic1_s1_q, ic1_s2_q, ic1_s3_q;
  logic       ic2_s1_q, ic2_s2_q, ic2_s3_q;
  logic [2:0] ext_gap_q;

  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic rising);
    edge_hit = rising ? (!prev && cur) : (prev && !cur);
  endfunction

  // address phase capture; one wait-free data phase
  wire a_ph = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
      dp_q  <= FRT_DP_IDLE;
    end else begin
      req_q.sel  <= a_ph;
      req_q.wr   <= hwrite;
      req_q.addr <= haddr[7:0];
      dp_q       <= a_ph ? FRT_DP_BUSY : FRT_DP_IDLE;
    end
  end

  wire rd_acc = req_q.sel && !req_q.wr;
  wire wr_acc = req_q.sel && req_q.wr;
  function automatic logic hit(input logic [7:0] off);
    hit = req_q.sel && (req_q.addr == off);
  endfunction
  wire acc_stat  = hit(`FRT_OFF_STAT) && !req_q.wr;
  wire acc_cntlo = hit(`FRT_OFF_CNT_LO);
  wire acc_acnlo = hit(`FRT_OFF_ACNT_LO);
  wire rd_cnthi  = rd_acc && (hit(`FRT_OFF_CNT_HI) || hit(`FRT_OFF_ACNT_HI));
  wire rd_cntlo  = rd_acc && (acc_cntlo || acc_acnlo);
  wire acc_c1lo  = hit(`FRT_OFF_CAP1_LO);
  wire acc_c2lo  = hit(`FRT_OFF_CAP2_LO) && !FLASH_VAR;
  wire rd_c1hi   = rd_acc && hit(`FRT_OFF_CAP1_HI);
  wire rd_c2hi   = rd_acc && hit(`FRT_OFF_CAP2_HI) && !FLASH_VAR;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl1_q <= 8'h00;
      ctrl2_q <= 8'h00;
      sys_q   <= 8'h00;
    end else if (wr_acc) begin
      if (hit(`FRT_OFF_CTRL1)) ctrl1_q <= hwdata[7:0];
      if (hit(`FRT_OFF_CTRL2)) ctrl2_q <= hwdata[7:0];
      if (hit(`FRT_OFF_SYS))   sys_q   <= hwdata[7:0];
    end
  end

  wire [1:0] clk_sel = ctrl2_q[`FRT_B_CC_LO +: 2];
  wire       halted  = sys_q[`FRT_B_HALT];
  wire       imask   = sys_q[`FRT_B_IMASK];
  wire       pulse_md = ctrl2_q[`FRT_B_OPM] || ctrl2_q[`FRT_B_PWM];

  // pins: a non-bonded input reads as one
  wire ext_pin = EXT_BONDED  ? ext_timer_clock_pin : 1'b1;
  wire ic1_pin = CAP1_BONDED ? capture_pin_one     : 1'b1;
  wire ic2_pin = CAP2_BONDED ? capture_pin_two     : 1'b1;

  // third stage only feeds edge detection, never the first flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ext_s1_q, ext_s2_q, ext_s3_q} <= 3'b111;
      {ic1_s1_q, ic1_s2_q, ic1_s3_q} <= 3'b111;
      {ic2_s1_q, ic2_s2_q, ic2_s3_q} <= 3'b111;
    end else begin
      {ext_s1_q, ext_s2_q, ext_s3_q} <= {ext_pin, ext_s1_q, ext_s2_q};
      {ic1_s1_q, ic1_s2_q, ic1_s3_q} <= {ic1_pin, ic1_s1_q, ic1_s2_q};
      {ic2_s1_q, ic2_s2_q, ic2_s3_q} <= {ic2_pin, ic2_s1_q, ic2_s2_q};
    end
  end

  wire ext_edge = edge_hit(ext_s3_q, ext_s2_q, ctrl2_q[`FRT_B_EXT_CLOCK_EDGE_SELECT]);
  // spacing guard: edges closer than the minimum gap are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ext_gap_q <= `FRT_EXT_GAP;
    else if (ext_edge && ext_gap_q >= `FRT_EXT_GAP) ext_gap_q <= 3'd1;
    else if (ext_gap_q < `FRT_EXT_GAP) ext_gap_q <= ext_gap_q + 3'd1;
  end

  // prescaler: cleared by counter low writes and held in halt, otherwise tick spacing is exact power of two
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pre_q <= 3'd0;
    else if (wr_acc && (acc_cntlo || acc_acnlo)) pre_q <= 3'd0;
    else if (!halted) pre_q <= pre_q + 3'd1;
  end

  logic tick;
  always_comb begin
    case (clk_sel)
      `FRT_CC_DIV2: tick = pre_q[0];
      `FRT_CC_DIV4: tick = pre_q[1:0] == 2'b11;
      `FRT_CC_DIV8: tick = pre_q == 3'b111;
      default:      tick = ext_edge && ext_gap_q >= `FRT_EXT_GAP;
    endcase
  end
  wire cnt_step = tick && !halted;
  wire cnt_load = wr_acc && (acc_cntlo || acc_acnlo);
  wire ovf_ev   = cnt_step && !cnt_load && cnt_q == `FRT_CNT_TOP;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_q <= `FRT_CNT_RELOAD;
    else if (cnt_load) cnt_q <= `FRT_CNT_RELOAD;
    else if (cnt_step) cnt_q <= cnt_q + 16'h0001;
  end

  // 16-bit read sequence latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_q      <= 1'b0;
      lo_latch_q <= 8'h00;
    end else if (rd_cnthi && !seq_q) begin
      seq_q      <= 1'b1;
      lo_latch_q <= cnt_q[7:0];
    end else if (rd_cntlo) begin
      seq_q <= 1'b0;
    end
  end

  // capture inhibit after high-byte read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap1_inh_q <= 1'b0;
      cap2_inh_q <= 1'b0;
    end else begin
      if (rd_c1hi) cap1_inh_q <= 1'b1;
      else if (rd_acc && acc_c1lo) cap1_inh_q <= 1'b0;
      if (rd_c2hi) cap2_inh_q <= 1'b1;
      else if (rd_acc && acc_c2lo) cap2_inh_q <= 1'b0;
    end
  end

  wire ic1_ev = edge_hit(ic1_s3_q, ic1_s2_q, ctrl1_q[`FRT_B_EDGE1])
                && !pulse_md && !cap1_inh_q;
  wire ic2_ev = edge_hit(ic2_s3_q, ic2_s2_q, ctrl2_q[`FRT_B_EDGE2])
                && !cap2_inh_q && !FLASH_VAR;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap1_q <= 16'h0000;
      cap2_q <= 16'h0000;
    end else begin
      if (ic1_ev) cap1_q <= cnt_q;
      if (ic2_ev) cap2_q <= cnt_q;
    end
  end

  // two-step flag clears; set beats clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_q <= 1'b0;
      ovf_arm_q <= 1'b0;
    end else begin
      if (acc_stat && ovf_q) ovf_arm_q <= 1'b1;
      else if (acc_cntlo) ovf_arm_q <= 1'b0;
      if (ovf_ev) ovf_q <= 1'b1;
      else if (acc_cntlo && ovf_arm_q) ovf_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cf1_q <= 1'b0;
      cf1_arm_q <= 1'b0;
      cf2_q <= 1'b0;
      cf2_arm_q <= 1'b0;
    end else begin
      if (acc_stat && cf1_q) cf1_arm_q <= 1'b1;
      else if (acc_c1lo) cf1_arm_q <= 1'b0;
      if (ic1_ev) cf1_q <= 1'b1;
      else if (acc_c1lo && cf1_arm_q) cf1_q <= 1'b0;
      if (acc_stat && cf2_q) cf2_arm_q <= 1'b1;
      else if (acc_c2lo) cf2_arm_q <= 1'b0;
      if (ic2_ev) cf2_q <= 1'b1;
      else if (acc_c2lo && cf2_arm_q) cf2_q <= 1'b0;
    end
  end

  wire irq_d = !imask &&
               ((ovf_q && ctrl1_q[`FRT_B_OVFIE]) ||
                ((cf1_q || cf2_q) && ctrl1_q[`FRT_B_CAPIE]));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) timer_irq <= 1'b0;
    else timer_irq <= irq_d;
  end

  // read mux; unmapped offsets read zero, response always okay
  logic [7:0] rd_d;
  always_comb begin
    rd_d = 8'h00;
    case (haddr[7:0])
      `FRT_OFF_CTRL1:   rd_d = ctrl1_q;
      `FRT_OFF_CTRL2:   rd_d = ctrl2_q;
      `FRT_OFF_SYS:     rd_d = sys_q;
      `FRT_OFF_STAT:    rd_d = {cf1_q, cf2_q, ovf_q, 5'b00000};
      `FRT_OFF_CAP1_HI: rd_d = cap1_q[15:8];
      `FRT_OFF_CAP1_LO: rd_d = cap1_q[7:0];
      `FRT_OFF_CAP2_HI: rd_d = FLASH_VAR ? 8'h00 : cap2_q[15:8];
      `FRT_OFF_CAP2_LO: rd_d = FLASH_VAR ? 8'h00 : cap2_q[7:0];
      `FRT_OFF_CNT_HI,
      `FRT_OFF_ACNT_HI: rd_d = cnt_q[15:8];
      `FRT_OFF_CNT_LO,
      `FRT_OFF_ACNT_LO: rd_d = seq_q ? lo_latch_q : cnt_q[7:0];
      default:          rd_d = 8'h00;
    endcase
  end

  // data is fetched in address phase, so the read sees pre-access state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (a_ph && !hwrite) hrdata <= {24'h0, rd_d};
    end
  end

  // status read, one cycle with no counter low access, then the counter low access
  sequence stat_then_lo_s;
    acc_stat && ovf_q ##1 !acc_cntlo ##1 (acc_cntlo && !ovf_ev);
  endsequence

  ovf_seq_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    stat_then_lo_s |=> !ovf_q) else $error("overflow flag kept");

  ovf_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_ev |=> ovf_q) else $error("overflow flag not set");
  ovf_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(cnt_q) == 16'hffff && cnt_q == 16'h0000) |-> ovf_q)
    else $error("wrap without overflow flag");
  ovf_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_q && !acc_cntlo && !$past(acc_cntlo) |=> ovf_q)
    else $error("overflow flag dropped without low access");
  reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cnt_load |=> cnt_q == 16'hfffc) else $error("reload not fffc");
  halt_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    halted && !cnt_load |=> $stable(cnt_q)) else $error("count moved in halt");
  cap_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ic2_ev |=> cap2_q == $past(cnt_q) && cf2_q)
    else $error("capture two missing");
  cap_inhibit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cap1_inh_q |=> cap1_q == $past(cap1_q))
    else $error("capture while inhibited");
  pulse_cap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pulse_md |-> !ic1_ev) else $error("channel one captured in pulse mode");
  irq_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(imask) |-> !timer_irq) else $error("irq while masked");
  div2_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_sel == 2'b00 && !halted && !cnt_load ##1
    clk_sel == 2'b00 && !halted && !cnt_load |=> cnt_q != $past(cnt_q, 2))
    else $error("div2 rate wrong");
endmodule
`default_nettype wire

// *** tb/frt_timer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "frt_cfg.svh"
module frt_timer_bench;
  logic        hclk, hresetn, hsel, hwrite, cap1, cap2, ext;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, irq;
  logic [15:0] d, lo;
  wire logic   hready;
  int          errors = 0;
  int          n_tests = 0;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  frt_timer DUT (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hready),
    .hrdata              (hrdata),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .capture_pin_one     (cap1),
    .capture_pin_two     (cap2),
    .ext_timer_clock_pin (ext),
    .timer_irq           (irq)
  );

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic wrap_up();
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] t;
    bus(1'b1, a, wd, t);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h00000000, v);
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask

  task automatic rc(input string n, input logic [7:0] a,
                    input logic [31:0] e);
    rd(a);
    chk(n, e, v);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // 16-bit read through the alternate view, leaves the overflow flag alone
  task automatic rd_alt();
    rd(`FRT_OFF_ACNT_HI);
    d[15:8] = v[7:0];
    rd(`FRT_OFF_ACNT_LO);
    d[7:0] = v[7:0];
  endtask

  initial begin
    #1_000_000;
    errors++;
    wrap_up();
  end

  initial begin
    // pins idle high, the level the input synchronisers reset to
    {hsel, hwrite, hresetn} = '0;
    {cap1, cap2, ext} = 3'b111;
    haddr = '0;
    hwdata = '0;
    htrans = 2'b00;
    hsize = 3'b010;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc("reset count hi", `FRT_OFF_CNT_HI, 32'hff);
    rc("reset status", `FRT_OFF_STAT, 32'h0);
    rd(`FRT_OFF_CNT_LO);
    // tick rate per prescaler setting; the low write zeroes the prescaler, counts are accepted from nominal up to 2 above
    for (int i = 0; i < 3; i++) begin
      wr(`FRT_OFF_CTRL2, 32'(i) << 2);
      wr(`FRT_OFF_CNT_LO, 32'h0);
      cyc(160);
      rd_alt();
      d = d - 16'hfffc;
      lo = 16'(80 >> i);
      n_tests++;
      if (((d >= lo) && (d <= lo + 16'd2)) !== 1'b1) begin
        $display("mismatch tick count expected %h seen %h", lo, d);
        errors++;
      end
    end
    wr(`FRT_OFF_CTRL2, 32'h0);
    wr(`FRT_OFF_SYS, 32'h2);
    wr(`FRT_OFF_CNT_LO, 32'h0);
    cyc(20);
    rc("halted hi", `FRT_OFF_CNT_HI, 32'hff);
    wr(`FRT_OFF_SYS, 32'h0);
    cyc(40);
    rc("resumed hi", `FRT_OFF_CNT_HI, 32'h0);
    rc("latched lo", `FRT_OFF_CNT_LO, 32'hfc);
    wr(`FRT_OFF_SYS, 32'h2);
    rd_alt();
    rc("live lo", `FRT_OFF_CNT_LO, {24'h0, d[7:0]});
    wr(`FRT_OFF_SYS, 32'h0);
    rd(`FRT_OFF_STAT);
    rd(`FRT_OFF_CNT_LO);
    wr(`FRT_OFF_CTRL1, 32'h20);
    wr(`FRT_OFF_CNT_LO, 32'h0);
    cyc(20);
    rd(`FRT_OFF_CNT_LO);
    rc("ovf set", `FRT_OFF_STAT, 32'h20);
    chk("irq ovf", 32'h1, {31'h0, irq});
    wr(`FRT_OFF_SYS, 32'h1);
    cyc(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`FRT_OFF_SYS, 32'h0);
    cyc(2);
    chk("irq pending", 32'h1, {31'h0, irq});
    rd(`FRT_OFF_ACNT_LO);
    rc("ovf kept", `FRT_OFF_STAT, 32'h20);
    rd(`FRT_OFF_CNT_LO);
    rc("ovf cleared", `FRT_OFF_STAT, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    // pin edges spaced 8 cycles apart, inside the allowed rate
    for (int e = 0; e < 2; e++) begin
      wr(`FRT_OFF_CTRL2, 32'hc | 32'(e));
      wr(`FRT_OFF_CNT_LO, 32'h0);
      repeat (5) begin
        ext <= 1'b1;
        cyc(8);
        ext <= 1'b0;
        cyc(8);
      end
      rd_alt();
      chk("ext count", 32'h1, {16'h0, d});
      rc("ext wrap", `FRT_OFF_STAT, 32'h20);
      rd(`FRT_OFF_CNT_LO);
    end
    wr(`FRT_OFF_CTRL2, 32'h2);
    wr(`FRT_OFF_SYS, 32'h2);
    wr(`FRT_OFF_CNT_LO, 32'h0);
    wr(`FRT_OFF_CTRL1, 32'h82);
    cap1 <= 1'b0;
    cyc(6);
    cap1 <= 1'b1;
    cyc(6);
    rc("cap1 flag", `FRT_OFF_STAT, 32'h80);
    chk("irq cap", 32'h1, {31'h0, irq});
    rc("cap1 hi", `FRT_OFF_CAP1_HI, 32'hff);
    rc("cap1 lo", `FRT_OFF_CAP1_LO, 32'hfc);
    rc("cap1 clr", `FRT_OFF_STAT, 32'h0);
    rd(`FRT_OFF_CAP1_HI);
    cap1 <= 1'b0;
    cyc(6);
    cap1 <= 1'b1;
    cyc(6);
    rc("cap1 inhibit", `FRT_OFF_STAT, 32'h0);
    rd(`FRT_OFF_CAP1_LO);
    cap1 <= 1'b0;
    cyc(6);
    cap1 <= 1'b1;
    cyc(6);
    rc("cap1 again", `FRT_OFF_STAT, 32'h80);
    rd(`FRT_OFF_CAP1_LO);
    wr(`FRT_OFF_CTRL2, 32'h12);
    cap1 <= 1'b0;
    cyc(6);
    cap1 <= 1'b1;
    cyc(6);
    rc("cap1 pulse mode", `FRT_OFF_STAT, 32'h0);
    cap2 <= 1'b0;
    cyc(6);
    rc("cap2 wrong edge", `FRT_OFF_STAT, 32'h0);
    cap2 <= 1'b1;
    cyc(6);
    rc("cap2 flag", `FRT_OFF_STAT, 32'h40);
    rc("cap2 lo", `FRT_OFF_CAP2_LO, 32'hfc);
    rc("cap2 clr", `FRT_OFF_STAT, 32'h0);
    wr(8'h30, 32'hff);
    rc("unmapped", 8'h30, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
